/* shared/ppfm_pkg.sv */
// Purpose: shared constants for the port pin function mux
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   all offsets are byte addresses
package ppfm_pkg;
   localparam logic [7:0] P3DIR_OFS    = 8'h00;
   localparam logic [7:0] P3LAT_OFS    = 8'h04;
   localparam logic [7:0] P3PIN_OFS    = 8'h08;
   localparam logic [7:0] P9DIR_OFS    = 8'h0c;
   localparam logic [7:0] P9DAT_OFS    = 8'h10;
   localparam logic [7:0] CTRL_OFS     = 8'h14;
   localparam logic [7:0] STAT_OFS     = 8'h18;
   localparam logic [7:0] P3DIR_RST    = 8'h00;
   localparam logic [7:0] P3LAT_RST    = 8'h00;
   localparam logic [7:0] P9DIR_RST    = 8'h00;
   localparam logic [7:0] P9LAT_RST    = 8'h00;
   localparam logic [7:0] CTRL_RST     = 8'h00;
   // control register fields
   localparam int CTRL_EXPAND_BIT  = 0;
   localparam int CTRL_HAPE_BIT    = 1;
   localparam int CTRL_PWREV_BIT   = 2;
   localparam int CTRL_P80D_BIT    = 3;
   localparam int CTRL_WAITSEL_BIT = 4;
   localparam int CTRL_I2CE_BIT = 5;
   localparam int CTRL_PMEO_BIT = 6;
   localparam int CTRL_WIDTH    = 7;
   // port 9 positions
   localparam int P9_CLKIN_BIT  = 6;
   localparam int P9_MUXED_BIT  = 7;
   // mode pin codes
   typedef enum logic [1:0]
   {
      PPFM_MODE0 = 2'b00,
      PPFM_MODE1 = 2'b01,
      PPFM_MODE2 = 2'b10,
      PPFM_MODE3 = 2'b11
   } ppfm_mode_t;
endpackage

/* hdl/ppfm_sync.sv */
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: inputs are asynchronous to REF_CLK
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
module ppfm_sync
#(
   parameter int W = 8
)
(
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;

   // two flops, nothing taps the first
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

/* hdl/ppfm_top.sv */
// Purpose: port 3, port 9 and pin 80 function multiplexing with APB registers
// Assumes: mode pins are static during operation; SRST synchronous
// Notes:   two-way pins appear as in, out and output enable
`timescale 1ns/100ps

// How it works
// R1 - expanded: port 3 is data bus, direction ignored
// R2 - single-chip: port 3 direction bit picks output
// R3 - pin 80 plain I/O by its direction
// R4 - host address enable makes pin 80 input in single-chip mode
// R5 - software keeps other bits clear with power-event
// R6 - port 9 latch drives output pins
// R7 - port 9 output bits read the latch
// R8 - port 9 input bits read the pin
// R9 - port 9 bit 6 reads live pin only
// R10 - expanded: pin 97 wait, else i2c, else I/O
// R11 - single-chip: pin 97 i2c or plain I/O
// R12 - i2c on pin 97 is open drain
// R13 - single-chip port 3 outputs drive latch
// R14 - modes 2,3 start single-chip until expansion set
module ppfm_top
(
   input  wire logic              REF_CLK,
   input  wire logic              SRST,
   input  wire logic [7:0]        PADDR,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [31:0]       PWDATA,
   input  wire logic [3:0]        PSTRB,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire ppfm_pkg::ppfm_mode_t MODE_PINS,
   input  wire logic [7:0]        P3_IN,
   output logic      [7:0]        P3_OUT,
   output logic      [7:0]        P3_OE,
   input  wire logic [7:0]        BUS_DATA_OUT,
   input  wire logic              BUS_DATA_DRIVE,
   output logic      [7:0]        BUS_DATA_IN,
   input  wire logic [7:0]        P9_IN,
   output logic      [7:0]        P9_OUT,
   output logic      [7:0]        P9_OE,
   input  wire logic              P80_IN,
   output logic                   P80_OUT,
   output logic                   P80_OE,
   output logic                   HOST_ADDR_BIT0,
   input  wire logic              POWER_EVENT_OUT,
   output logic                   BUS_WAIT,
   input  wire logic              I2C0_DATA_OUT,
   output logic                   I2C0_DATA_IN,
   output logic                   EXPANDED
);
   import ppfm_pkg::*;

   logic [7:0]            p3_dir_reg;
   logic [7:0]            p3_lat_reg;
   logic [7:0]            p9_dir_reg;
   logic [7:0]            p9_lat_reg;
   logic [CTRL_WIDTH-1:0] ctrl_reg;
   logic [7:0]            p3_pin;
   logic [7:0]            p9_pin;
   logic                  p80_pin;
   logic [7:0]            p9_read;
   logic [31:0]           rdata_next;
   logic                  wr_en;
   logic                  rd_en;
   logic                  addr_ok;
   logic                  exp_en;
   logic                  mode_exp_only;
   logic                  single_chip;
   logic                  hape;
   logic                  pwr_evt_en;
   logic                  p80_dir;
   logic                  wait_sel;
   logic                  i2ce;
   logic [2:0]            pin97_sel;

   // pin 97 function codes
   localparam logic [2:0] PIN97_IO   = 3'h0;
   localparam logic [2:0] PIN97_WAIT = 3'h1;
   localparam logic [2:0] PIN97_I2C  = 3'h2;

   // decode used by the write enable and the error response; the read mux does not use it
   function automatic logic ofs_known(input logic [7:0] a);
      ofs_known = (a == P3DIR_OFS) || (a == P3LAT_OFS) || (a == P3PIN_OFS) ||
                  (a == P9DIR_OFS) || (a == P9DAT_OFS) || (a == CTRL_OFS)  ||
                  (a == STAT_OFS);
   endfunction

   // pins come from the board, so every level is synchronised first
   ppfm_sync #(.W(8)) u_sync_p3
   (
      .clk      (REF_CLK),
      .srst     (SRST),
      .async_in (P3_IN),
      .sync_out (p3_pin)
   );

   ppfm_sync #(.W(8)) u_sync_p9
   (
      .clk      (REF_CLK),
      .srst     (SRST),
      .async_in (P9_IN),
      .sync_out (p9_pin)
   );

   ppfm_sync #(.W(1)) u_sync_p80
   (
      .clk      (REF_CLK),
      .srst     (SRST),
      .async_in (P80_IN),
      .sync_out (p80_pin)
   );

   // apb: zero wait states, error on unmapped offsets
   assign addr_ok = ofs_known(PADDR);
   assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok && PSTRB[0];
   assign rd_en   = PSEL && !PENABLE && !PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   // control bits
   assign exp_en        = ctrl_reg[CTRL_EXPAND_BIT];
   assign hape          = ctrl_reg[CTRL_HAPE_BIT];
   assign pwr_evt_en    = ctrl_reg[CTRL_PWREV_BIT];
   assign p80_dir       = ctrl_reg[CTRL_P80D_BIT];
   assign wait_sel      = ctrl_reg[CTRL_WAITSEL_BIT];
   assign i2ce          = ctrl_reg[CTRL_I2CE_BIT];
   assign mode_exp_only = (MODE_PINS == PPFM_MODE1);
   // modes 2,3 leave reset single-chip; expansion bit is clear after reset
   assign EXPANDED      = mode_exp_only || exp_en; // R14
   assign single_chip   = !EXPANDED;

   // port 3 direction, write only
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         p3_dir_reg <= P3DIR_RST;
      else if (wr_en && PADDR == P3DIR_OFS)
         p3_dir_reg <= PWDATA[7:0];
   end

   // port 3 output latch
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         p3_lat_reg <= P3LAT_RST;
      else if (wr_en && PADDR == P3LAT_OFS)
         p3_lat_reg <= PWDATA[7:0];
   end

   // port 9 direction
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         p9_dir_reg <= P9DIR_RST;
      else if (wr_en && PADDR == P9DIR_OFS)
         p9_dir_reg <= PWDATA[7:0];
   end

   // port 9 latch; bit 6 has no storage behind it
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         p9_lat_reg <= P9LAT_RST;
      else if (wr_en && PADDR == P9DAT_OFS)
      begin
         p9_lat_reg <= PWDATA[7:0];
         p9_lat_reg[P9_CLKIN_BIT] <= 1'b0; // R9
      end
   end

   // control register; expansion bit is software set only
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         ctrl_reg <= CTRL_RST[CTRL_WIDTH-1:0]; // R14
      else if (wr_en && PADDR == CTRL_OFS)
         ctrl_reg <= PWDATA[CTRL_WIDTH-1:0];
   end

   // port 3: data bus takes over when expanded, direction bits ignored
   always_comb
   begin
      if (EXPANDED)
      begin
         P3_OUT = BUS_DATA_OUT; // R1
         P3_OE  = {8{BUS_DATA_DRIVE}}; // R1
      end
      else
      begin
         P3_OUT = p3_lat_reg; // R13
         P3_OE  = p3_dir_reg; // R2
      end
   end
   assign BUS_DATA_IN = p3_pin;

   // pin 80: power event over host address over plain I/O
   always_comb
   begin
      if (pwr_evt_en)
      begin
         // software keeps the other two bits clear here
         P80_OUT = POWER_EVENT_OUT; // R5
         P80_OE  = 1'b1;
      end
      else if (hape && single_chip)
      begin
         P80_OUT = 1'b0; // R4
         P80_OE  = 1'b0; // R4
      end
      else
      begin
         P80_OUT = 1'b0; // no pin 80 latch in this block, so output is low
         P80_OE  = p80_dir; // R3
      end
   end
   // host address only valid in single-chip modes
   assign HOST_ADDR_BIT0 = (!pwr_evt_en && hape && single_chip) ? p80_pin : 1'b0; // R4

   // pin 97 selection
   always_comb
   begin
      if (EXPANDED && wait_sel)
         pin97_sel = PIN97_WAIT; // R10
      else if (i2ce)
         pin97_sel = PIN97_I2C; // R10 R11
      else
         pin97_sel = PIN97_IO; // R11
   end

   // port 9 drivers; bit 6 is clock input only, never driven
   always_comb
   begin
      P9_OUT = p9_lat_reg; // R6
      P9_OE  = p9_dir_reg;
      P9_OE[P9_CLKIN_BIT] = 1'b0;
      unique case (pin97_sel)
         PIN97_WAIT:
         begin
            P9_OUT[P9_MUXED_BIT] = 1'b0;
            P9_OE[P9_MUXED_BIT]  = 1'b0;
         end
         PIN97_I2C:
         begin
            // open drain: drive low or release
            P9_OUT[P9_MUXED_BIT] = 1'b0; // R12
            P9_OE[P9_MUXED_BIT]  = !I2C0_DATA_OUT; // R12
         end
         default:
         begin
            P9_OUT[P9_MUXED_BIT] = p9_lat_reg[P9_MUXED_BIT]; // R11
            P9_OE[P9_MUXED_BIT]  = p9_dir_reg[P9_MUXED_BIT];
         end
      endcase
   end
   assign BUS_WAIT     = (pin97_sel == PIN97_WAIT) ? p9_pin[P9_MUXED_BIT] : 1'b1;
   assign I2C0_DATA_IN = (pin97_sel == PIN97_I2C) ? p9_pin[P9_MUXED_BIT] : 1'b1;

   // port 9 read: latch for outputs, pin for inputs, bit 6 always pin
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_p9rd
         if (gi == P9_CLKIN_BIT)
         begin : g_live
            assign p9_read[gi] = p9_pin[gi]; // R9
         end
         else
         begin : g_mix
            assign p9_read[gi] = p9_dir_reg[gi] ? p9_lat_reg[gi] // R7
                                                : p9_pin[gi]; // R8
         end
      end
   endgenerate

   // read mux; port 3 direction register reads as zero since it is write only
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      unique case (PADDR)
         P3LAT_OFS: rdata_next[7:0] = p3_lat_reg;
         P3PIN_OFS: rdata_next[7:0] = p3_pin;
         P9DIR_OFS: rdata_next[7:0] = p9_dir_reg;
         P9DAT_OFS: rdata_next[7:0] = p9_read;
         CTRL_OFS:  rdata_next[CTRL_WIDTH-1:0] = ctrl_reg;
         STAT_OFS:  rdata_next[0] = EXPANDED;
         default:   rdata_next = 32'h0000_0000;
      endcase
   end

   // read data captured in setup phase, held through access
   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
         PRDATA <= 32'h0000_0000;
      else if (rd_en)
         PRDATA <= rdata_next;
   end

   // expanded mode ignores the port 3 direction bits
   chk_p3_bus_owns: assert property (@(posedge REF_CLK) disable iff (SRST) // R1
      EXPANDED |-> (P3_OE == {8{BUS_DATA_DRIVE}} && P3_OUT == BUS_DATA_OUT))
      else $error("port 3 not handed to bus when expanded");

   chk_p3_dir_out: assert property (@(posedge REF_CLK) disable iff (SRST) // R2
      !EXPANDED |-> (P3_OE == p3_dir_reg && P3_OUT == p3_lat_reg))
      else $error("port 3 single-chip drive mismatch");

   chk_p80_plain: assert property (@(posedge REF_CLK) disable iff (SRST) // R3
      (!pwr_evt_en && !hape) |-> (P80_OE == p80_dir))
      else $error("pin 80 plain direction wrong");

   chk_p80_hostaddr: assert property (@(posedge REF_CLK) disable iff (SRST) // R4
      (!pwr_evt_en && hape && single_chip) |-> (!P80_OE && HOST_ADDR_BIT0 == p80_pin))
      else $error("pin 80 not host address input");

   chk_p9_latch_out: assert property (@(posedge REF_CLK) disable iff (SRST) // R6
      (wr_en && PADDR == P9DAT_OFS) |=> (P9_OUT[0] == $past(PWDATA[0])))
      else $error("port 9 latch not driven");

   chk_p9_read_mix: assert property (@(posedge REF_CLK) disable iff (SRST) // R7
      (rd_en && PADDR == P9DAT_OFS && p9_dir_reg[0])
      |=> (PRDATA[0] == $past(p9_lat_reg[0])))
      else $error("port 9 output bit read wrong");

   chk_p9_read_pin: assert property (@(posedge REF_CLK) disable iff (SRST) // R8
      (rd_en && PADDR == P9DAT_OFS && !p9_dir_reg[1])
      |=> (PRDATA[1] == $past(p9_pin[1])))
      else $error("port 9 input bit read wrong");

   chk_pin96_live: assert property (@(posedge REF_CLK) disable iff (SRST) // R9
      (rd_en && PADDR == P9DAT_OFS)
      |=> (PRDATA[P9_CLKIN_BIT] == $past(p9_pin[P9_CLKIN_BIT])))
      else $error("port 9 bit 6 not live");

   chk_pin97_wait: assert property (@(posedge REF_CLK) disable iff (SRST) // R10
      (EXPANDED && wait_sel) |-> (!P9_OE[P9_MUXED_BIT]))
      else $error("pin 97 driven while wait input");

   chk_pin97_i2c_od: assert property (@(posedge REF_CLK) disable iff (SRST) // R12
      (pin97_sel == PIN97_I2C && P9_OE[P9_MUXED_BIT]) |-> !P9_OUT[P9_MUXED_BIT])
      else $error("i2c data line driven high");

   chk_pin97_single: assert property (@(posedge REF_CLK) disable iff (SRST) // R11
      (single_chip && !i2ce) |-> (P9_OE[P9_MUXED_BIT] == p9_dir_reg[P9_MUXED_BIT]))
      else $error("pin 97 single-chip direction wrong");

   chk_start_single: assert property (@(posedge REF_CLK) // R14
      ($past(SRST) && !SRST && !mode_exp_only) |-> !EXPANDED)
      else $error("left reset expanded");
endmodule

/* verif/ppfm_board.sv */
// Purpose: board circuitry on the port 3, port 9 and pin 80 pins
// Assumes: pins resolve at once; device drive wins over the board
// Notes:   undriven pins show the board level, pull-up included
`timescale 1ns/100ps
module ppfm_board
(
   input  wire logic [7:0] p3_out,
   input  wire logic [7:0] p3_oe,
   input  wire logic [7:0] p9_out,
   input  wire logic [7:0] p9_oe,
   input  wire logic       p80_out,
   input  wire logic       p80_oe,
   input  wire logic [7:0] p3_ext,
   input  wire logic [7:0] p9_ext,
   input  wire logic       p80_ext,
   output logic      [7:0] p3_pin,
   output logic      [7:0] p9_pin,
   output logic            p80_pin
);
   // wire level per bit; the i2c line level comes from p9_ext bit 7
   assign p3_pin  = (p3_oe & p3_out) | (~p3_oe & p3_ext);
   assign p9_pin  = (p9_oe & p9_out) | (~p9_oe & p9_ext);
   assign p80_pin = p80_oe ? p80_out : p80_ext;
endmodule

/* verif/ppfm_top_tb.sv */
// Purpose: self-checking bench for the port pin function mux
// Assumes: zero-wait APB slave, pins seen two edges after a change
// Notes:   table rows first, then mode and pin function cases
`timescale 1ns/100ps
module ppfm_top_tb;
   import ppfm_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ppfm_row_t;
   logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, p3_out, p3_oe, p9_out, p9_oe, p3_pin, p9_pin, p3_ext, p9_ext;
   logic [7:0]  bus_out, bus_in;
   logic [31:0] pwdata, prdata, rd;
   ppfm_mode_t  mode;
   logic        p80_out, p80_oe, p80_pin, p80_ext, host_a0, pwr_evt, bus_drv;
   logic        bus_wait, i2c_out, i2c_in, expanded;
   int          err_count, n_checks;
   ppfm_row_t   rows[7] = '{'{8'h00, 8'h0f, 8'h00}, '{8'h04, 8'ha5, 8'ha5},
                           '{8'h0c, 8'hc1, 8'hc1}, '{8'h08, 8'hff, 8'h35},
                           '{8'h14, 8'h00, 8'h00}, '{8'h1c, 8'hff, 8'h00},
                           '{8'h18, 8'hff, 8'h00}};

   ppfm_top ppfm_top_inst (.REF_CLK(ref_clk), .SRST(srst), .PADDR(paddr), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .MODE_PINS(mode), .P3_IN(p3_pin),
      .P3_OUT(p3_out), .P3_OE(p3_oe), .BUS_DATA_OUT(bus_out), .BUS_DATA_DRIVE(bus_drv),
      .BUS_DATA_IN(bus_in), .P9_IN(p9_pin), .P9_OUT(p9_out), .P9_OE(p9_oe),
      .P80_IN(p80_pin), .P80_OUT(p80_out), .P80_OE(p80_oe), .HOST_ADDR_BIT0(host_a0),
      .POWER_EVENT_OUT(pwr_evt), .BUS_WAIT(bus_wait), .I2C0_DATA_OUT(i2c_out),
      .I2C0_DATA_IN(i2c_in), .EXPANDED(expanded));

   ppfm_board ppfm_board_inst (.p3_out(p3_out), .p3_oe(p3_oe), .p9_out(p9_out),
      .p9_oe(p9_oe), .p80_out(p80_out), .p80_oe(p80_oe), .p3_ext(p3_ext),
      .p9_ext(p9_ext), .p80_ext(p80_ext), .p3_pin(p3_pin), .p9_pin(p9_pin),
      .p80_pin(p80_pin));

   // free-running clock, 40 ns period
   initial ref_clk = 1'b0;
   always #20 ref_clk = ~ref_clk;

   task summarize;
      if (err_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // wait n rising edges, then sample at the falling edge where all is settled
   task settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // one apb transfer; the request holds until pready is seen high
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         err_count++;
         summarize;
      end
      rd = prdata;
      chk("slverr", pslverr, a > 8'h18);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // control write, then let outputs settle
   task ctl(input logic [7:0] d);
      apb(8'h14, 1'b1, {24'h0, d});
      settle(3);
   endtask

   // reset starts on a rising edge so mode and reset never move mid-cycle
   task rst(input ppfm_mode_t m);
      @(posedge ref_clk);
      srst <= 1'b1;
      mode <= m;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      settle(2);
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      summarize;
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, bus_out, bus_drv} = '0;
      srst = 1'b1;
      {pwr_evt, i2c_out, p80_ext} = 3'b011;
      p3_ext = 8'h3c;
      p9_ext = 8'hbc;
      mode = PPFM_MODE2;
      rst(PPFM_MODE2);
      chk("expanded", expanded, 1'b0);
      apb(8'h0c, 1'b0, 0);
      chk("p9dir rst", rd, 0);
      foreach (rows[i])
      begin
         apb(rows[i].a, 1'b1, {24'h0, rows[i].d});
         apb(rows[i].a, 1'b0, 0);
         chk("row", rd, {24'h0, rows[i].e});
      end
      settle(0);
      chk("p3 oe", p3_oe, 8'h0f);
      chk("p3 out", p3_out & p3_oe, 8'h05);
      // port 9 read mix: output bits from latch, the rest and bit 6 from pins
      @(posedge ref_clk);
      p9_ext <= 8'h3c;
      apb(8'h10, 1'b1, 32'h55);
      settle(3);
      apb(8'h10, 1'b0, 0);
      chk("p9 read", rd, 32'h3d);
      chk("p9 oe", p9_oe, 8'h81);
      chk("p9 out", p9_out & p9_oe, 8'h01);
      p9_ext <= 8'h7c;
      settle(3);
      apb(8'h10, 1'b0, 0);
      chk("pin96 live", rd, 32'h7d);
      // pin 80 functions
      ctl(8'h08);
      chk("p80 oe out", p80_oe, 1'b1);
      ctl(8'h00);
      chk("p80 oe in", p80_oe, 1'b0);
      ctl(8'h0a);
      chk("p80 ha oe", p80_oe, 1'b0);
      chk("haddr hi", host_a0, 1'b1);
      @(posedge ref_clk);
      p80_ext <= 1'b0;
      settle(3);
      chk("haddr lo", host_a0, 1'b0);
      @(posedge ref_clk);
      pwr_evt <= 1'b1;
      ctl(8'h04);
      chk("pme oe", p80_oe, 1'b1);
      chk("pme out", p80_out, 1'b1);
      // the pin must follow the event source, not sit at a constant
      @(posedge ref_clk);
      pwr_evt <= 1'b0;
      settle(1);
      chk("pme out lo", p80_out, 1'b0);
      // pin 97 in single-chip: wait select has no effect
      ctl(8'h10);
      chk("pin97 oe", p9_oe[7], 1'b1);
      chk("no wait", bus_wait, 1'b1);
      ctl(8'h30);
      chk("sda rel", p9_oe[7], 1'b0);
      @(posedge ref_clk);
      i2c_out <= 1'b0;
      settle(3);
      chk("sda low", {p9_oe[7], p9_out[7]}, 2'b10);
      chk("sda in", i2c_in, 1'b0);
      // expansion: port 3 becomes data bus
      ctl(8'h01);
      chk("expanded", expanded, 1'b1);
      @(posedge ref_clk);
      bus_out <= 8'hc3;
      bus_drv <= 1'b1;
      settle(1);
      chk("bus oe", p3_oe, 8'hff);
      chk("bus out", p3_out, 8'hc3);
      @(posedge ref_clk);
      bus_drv <= 1'b0;
      settle(3);
      chk("bus rel", p3_oe, 8'h00);
      chk("bus in", bus_in, 8'h3c);
      ctl(8'h11);
      chk("wait pin", {bus_wait, p9_oe[7]}, 2'b00);
      ctl(8'h21);
      chk("exp sda", p9_oe[7], 1'b1);
      rst(PPFM_MODE1);
      chk("mode1", expanded, 1'b1);
      chk("rst oe", {p3_oe, p9_oe}, 16'h0);
      summarize;
   end
endmodule
